// File: design/artp_map.svh
// Function
// - Compare shadows reload from duty only at overflow.
// - Four PWM channels, stopped during halt.
// - Enabled channel drives its pin push-pull.
// - Shared period is 256 minus reload value.
// - Overflow sets pin to polarity-selected level.
// - Compare match restores pin's opposite level.
// - Overflow sets flag; interrupt when enabled.
// - Flag set on wrap, cleared by status read.
// - Event mode counts 256 minus reload events.
// - Selected capture edge latches counter, sets flag.
// - Capture blocked until read; read clears flag.
// - Capture interrupt holds while flag and enable.
// - Enabled capture interrupts wake system from halt.
// - Bit 7 selects CPU or external clock.
// - Bits 6:4 divide by two to field.
// - Run enable zero freezes prescaler and counter.
// - Force reload writes only, reads zero.
// - Counter register reads live, writes anytime.
// - Overflow reloads counter and updates PWM levels.
// - Eight-bit up-counter ticks per prescaler output.
// - Polarity picks level at or below compare.
// - Reset clears counter, prescaler, selects CPU clock.
`ifndef ARTP_MAP_SVH
`define ARTP_MAP_SVH
`define ARTP_OFS_DUTY3 4'h0
`define ARTP_OFS_DUTY2 4'h1
`define ARTP_OFS_DUTY1 4'h2
`define ARTP_OFS_DUTY0 4'h3
`define ARTP_OFS_PWMCTL 4'h4
`define ARTP_OFS_CSR 4'h5
`define ARTP_OFS_CAR 4'h6
`define ARTP_OFS_ARR 4'h7
`define ARTP_OFS_ICCSR 4'h8
`define ARTP_OFS_ICR1 4'h9
`define ARTP_OFS_ICR2 4'hA
`define ARTP_CSR_CLKSEL 7
`define ARTP_CSR_DIV_HI 6
`define ARTP_CSR_DIV_LO 4
`define ARTP_CSR_RUN 3
`define ARTP_CSR_FRL 2
`define ARTP_CSR_OIE 1
`define ARTP_CSR_OVF 0
`define ARTP_RESET_BYTE 8'h00
`define ARTP_COUNT_TOP 8'hFF
`endif

// File: design/artp_pkg.sv
package artp_pkg;
  typedef logic [7:0] artp_byte_t;
  typedef struct packed {
    logic [3:0] out_enable;
    logic [3:0] polarity;
  } artp_pwmctl_s;
  typedef struct packed {
    logic clk_sel;
    logic [2:0] div_sel;
    logic run;
    logic overflow_irq_enable;
  } artp_csr_s;
  typedef struct packed {
    logic [1:0] edge_rise;
    logic [1:0] irq_en;
  } artp_capctl_s;
  typedef enum logic [1:0] {ARTP_IDLE, ARTP_DONE} artp_bus_e;
endpackage

// File: design/artp_timer.sv
// Our own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "artp_map.svh"
module artp_timer
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic halt_mode,
  input wire logic ext_clk_pin,
  input wire logic [1:0] capture_input_pin,
  output logic [3:0] pwm_out_pin,
  output logic [3:0] pwm_out_oe_n,
  output logic overflow_irq,
  output logic [1:0] capture_irq,
  output logic halt_wake
);
  import artp_pkg::*;

  // Bus state: one wait cycle, then the access completes.
  artp_bus_e bus_reg;
  logic acc;
  logic wr_go;
  logic rd_go;
  assign acc = (avs_read | avs_write) && bus_reg == ARTP_IDLE;
  assign wr_go = avs_write && bus_reg == ARTP_DONE && avs_byteenable[0];
  // Read side effects act on the edge that latches the read data. A flag set between
  // that latch and the end of the access is then kept for the next read, never lost.
  assign rd_go = avs_read && acc;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      bus_reg <= ARTP_IDLE;
    else if (acc)
      bus_reg <= ARTP_DONE;
    else
      bus_reg <= ARTP_IDLE;
  end

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  // Software registers.
  artp_byte_t duty_cycle_value [4];
  artp_pwmctl_s pwm_control;
  artp_csr_s csr_reg;
  artp_byte_t reload_value;
  artp_capctl_s capctl_reg;
  artp_byte_t wd;
  assign wd = avs_writedata[7:0];

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 4; i++)
        duty_cycle_value[i] <= `ARTP_RESET_BYTE;
      pwm_control <= '0;
      csr_reg <= '0;
      reload_value <= `ARTP_RESET_BYTE;
      capctl_reg <= '0;
    end
    else if (wr_go)
    begin
      for (int i = 0; i < 4; i++)
        if (hit(avs_address, 4'(`ARTP_OFS_DUTY0 - i)))
          duty_cycle_value[i] <= wd;
      if (hit(avs_address, `ARTP_OFS_PWMCTL))
        pwm_control <= wd;
      if (hit(avs_address, `ARTP_OFS_CSR))
        csr_reg <= {wd[7:3], wd[`ARTP_CSR_OIE]};
      if (hit(avs_address, `ARTP_OFS_ARR))
        reload_value <= wd;
      if (hit(avs_address, `ARTP_OFS_ICCSR))
        capctl_reg <= wd[5:2];
    end
  end

  // External clock pin: three stages, a rise counts when stages two and three agree.
  logic [2:0] ext_sync_reg;
  logic ext_level_reg;
  logic ext_rise;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ext_sync_reg <= 3'h0;
      ext_level_reg <= 1'b0;
    end
    else
    begin
      ext_sync_reg <= {ext_sync_reg[1:0], ext_clk_pin};
      if (ext_sync_reg[1] == ext_sync_reg[2])
        ext_level_reg <= ext_sync_reg[2];
    end
  end
  assign ext_rise = (ext_sync_reg[1] == ext_sync_reg[2]) && ext_sync_reg[2] && !ext_level_reg;

  // Prescaler input: CPU clock every cycle or one external edge.
  logic input_tick;
  assign input_tick = csr_reg.clk_sel ? ext_rise : 1'b1;
  logic frl_go;
  logic car_wr;
  assign frl_go = wr_go && hit(avs_address, `ARTP_OFS_CSR) && wd[`ARTP_CSR_FRL];
  assign car_wr = wr_go && hit(avs_address, `ARTP_OFS_CAR);

  // Seven-bit prescaler; the tap is reached when all low bits are ones.
  logic [6:0] presc_reg;
  logic [6:0] tap_mask;
  logic count_tick;
  logic running;
  assign running = csr_reg.run && !halt_mode;
  assign tap_mask = 7'((8'h01 << csr_reg.div_sel) - 8'h01);
  assign count_tick = running && input_tick && ((presc_reg & tap_mask) == tap_mask);

  always_ff @(posedge core_clk)
  begin
    if (rst)
      presc_reg <= 7'h00;
    else if (frl_go || car_wr)
      presc_reg <= 7'h00;
    else if (running && input_tick)
      presc_reg <= presc_reg + 7'h01;
  end

  // Counter, its overflow and reload. Writes win over counting.
  artp_byte_t counter_reg;
  logic ovf_evt;
  assign ovf_evt = count_tick && counter_reg == `ARTP_COUNT_TOP && !frl_go && !car_wr;
  always_ff @(posedge core_clk)
  begin
    if (rst)
      counter_reg <= `ARTP_RESET_BYTE;
    else if (car_wr)
      counter_reg <= wd;
    else if (frl_go)
      counter_reg <= reload_value;
    else if (ovf_evt)
      counter_reg <= reload_value;
    else if (count_tick)
      counter_reg <= counter_reg + 8'h01;
  end

  // Overflow flag: set wins over the read that clears it.
  logic ovf_reg;
  logic csr_rd;
  assign csr_rd = rd_go && hit(avs_address, `ARTP_OFS_CSR);
  always_ff @(posedge core_clk)
  begin
    if (rst)
      ovf_reg <= 1'b0;
    else if (ovf_evt)
      ovf_reg <= 1'b1;
    else if (csr_rd)
      ovf_reg <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      overflow_irq <= 1'b0;
    else
      overflow_irq <= (ovf_reg | ovf_evt) && csr_reg.overflow_irq_enable;
  end

  // Hidden compare shadows, loaded only at overflow so duty never glitches mid-period.
  artp_byte_t compare_shadow [4];
  logic [3:0] pwm_raw_reg;
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : ch
      always_ff @(posedge core_clk)
      begin
        if (rst)
          compare_shadow[g] <= `ARTP_RESET_BYTE;
        else if (ovf_evt)
          compare_shadow[g] <= duty_cycle_value[g];
      end

      // Raw level is high while in the leading phase; polarity applied at the pin.
      always_ff @(posedge core_clk)
      begin
        if (rst)
          pwm_raw_reg[g] <= 1'b0;
        else if (halt_mode)
          pwm_raw_reg[g] <= pwm_raw_reg[g];
        else if (ovf_evt)
          pwm_raw_reg[g] <= 1'b1;
        else if (counter_reg == compare_shadow[g] && count_tick)
          pwm_raw_reg[g] <= 1'b0;
      end

      // Push-pull drive while enabled; polarity flips immediately.
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          pwm_out_pin[g] <= 1'b0;
          pwm_out_oe_n[g] <= 1'b1;
        end
        else
        begin
          pwm_out_pin[g] <= pwm_raw_reg[g] ^ pwm_control.polarity[g];
          pwm_out_oe_n[g] <= !pwm_control.out_enable[g];
        end
      end
    end
  endgenerate

  // Capture pins: three-stage synchronisers with agreement filter.
  logic [2:0] cap_sync_reg [2];
  logic [1:0] cap_level_reg;
  logic [1:0] cap_flag_reg;
  artp_byte_t capture_value [2];
  generate
    for (g = 0; g < 2; g++)
    begin : cap
      logic stable;
      logic edge_hit;
      logic rd_clr;
      assign stable = cap_sync_reg[g][1] == cap_sync_reg[g][2];
      assign edge_hit = stable && cap_sync_reg[g][2] != cap_level_reg[g]
        && cap_sync_reg[g][2] == capctl_reg.edge_rise[g];
      assign rd_clr = rd_go && hit(avs_address, 4'(`ARTP_OFS_ICR1 + g));

      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          cap_sync_reg[g] <= 3'h0;
          cap_level_reg[g] <= 1'b0;
        end
        else
        begin
          cap_sync_reg[g] <= {cap_sync_reg[g][1:0], capture_input_pin[g]};
          if (stable)
            cap_level_reg[g] <= cap_sync_reg[g][2];
        end
      end

      // Blocked while flag stands; a new edge in the read cycle still captures.
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          capture_value[g] <= `ARTP_RESET_BYTE;
          cap_flag_reg[g] <= 1'b0;
        end
        else if (edge_hit && (!cap_flag_reg[g] || rd_clr))
        begin
          capture_value[g] <= counter_reg;
          cap_flag_reg[g] <= 1'b1;
        end
        else if (rd_clr)
          cap_flag_reg[g] <= 1'b0;
      end

      always_ff @(posedge core_clk)
      begin
        if (rst)
          capture_irq[g] <= 1'b0;
        else
          capture_irq[g] <= cap_flag_reg[g] && capctl_reg.irq_en[g];
      end
    end
  endgenerate

  // Wake request out of halt from any enabled capture interrupt.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      halt_wake <= 1'b0;
    else
      halt_wake <= halt_mode && |(cap_flag_reg & capctl_reg.irq_en);
  end

  // Read mux; force-reload bit always reads as zero, unmapped reads zero.
  artp_byte_t rd_byte;
  always_comb
  begin
    rd_byte = `ARTP_RESET_BYTE;
    unique case (avs_address)
      `ARTP_OFS_DUTY3: rd_byte = duty_cycle_value[3];
      `ARTP_OFS_DUTY2: rd_byte = duty_cycle_value[2];
      `ARTP_OFS_DUTY1: rd_byte = duty_cycle_value[1];
      `ARTP_OFS_DUTY0: rd_byte = duty_cycle_value[0];
      `ARTP_OFS_PWMCTL: rd_byte = pwm_control;
      `ARTP_OFS_CSR: rd_byte = {csr_reg[5:1], 1'b0, csr_reg.overflow_irq_enable, ovf_reg};
      `ARTP_OFS_CAR: rd_byte = counter_reg;
      `ARTP_OFS_ARR: rd_byte = reload_value;
      `ARTP_OFS_ICCSR: rd_byte = {2'b00, capctl_reg, cap_flag_reg};
      `ARTP_OFS_ICR1: rd_byte = capture_value[0];
      `ARTP_OFS_ICR2: rd_byte = capture_value[1];
      default: rd_byte = `ARTP_RESET_BYTE;
    endcase
  end

  // Read data is registered when the request is first seen, waitrequest drops next cycle.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      if (acc)
        avs_readdata <= {24'h00_0000, rd_byte};
      avs_waitrequest <= !acc;
    end
  end

  // Counter and overflow checks.
  chk_ovf_sets_flag: assert property (@(posedge core_clk) disable iff (rst)
    ovf_evt |=> ovf_reg) else $error("overflow flag not set");
  chk_ovf_reloads: assert property (@(posedge core_clk) disable iff (rst)
    ovf_evt |=> counter_reg == $past(reload_value)) else $error("no reload");
  chk_shadow_hold: assert property (@(posedge core_clk) disable iff (rst)
    !ovf_evt |=> compare_shadow[0] == $past(compare_shadow[0]))
    else $error("shadow changed");
  chk_frozen_counter: assert property (@(posedge core_clk) disable iff (rst)
    !csr_reg.run && !car_wr && !frl_go |=> $stable(counter_reg))
    else $error("counter moved");
  chk_frl_reload: assert property (@(posedge core_clk) disable iff (rst)
    frl_go |=> counter_reg == $past(reload_value) && presc_reg == 7'h00)
    else $error("force reload missed");
  chk_car_write: assert property (@(posedge core_clk) disable iff (rst)
    car_wr |=> counter_reg == $past(wd)) else $error("counter write lost");
  chk_ovf_irq: assert property (@(posedge core_clk) disable iff (rst)
    ovf_reg && csr_reg.overflow_irq_enable |=> overflow_irq) else $error("overflow irq low");

  // Capture steps: an edge taken while the channel is free, then value and flag latched.
  sequence artp_cap0_taken;
    cap[0].edge_hit && !cap_flag_reg[0];
  endsequence
  sequence artp_cap0_latched;
    cap_flag_reg[0] && capture_value[0] == $past(counter_reg);
  endsequence

  // Capture checks.
  chk_capture_flag: assert property (@(posedge core_clk) disable iff (rst)
    artp_cap0_taken |=> artp_cap0_latched)
    else $error("capture missed");
  chk_capture_block: assert property (@(posedge core_clk) disable iff (rst)
    cap_flag_reg[1] && !cap[1].rd_clr |=> $stable(capture_value[1]))
    else $error("capture overwritten");
  chk_cap_irq: assert property (@(posedge core_clk) disable iff (rst)
    cap_flag_reg[0] && capctl_reg.irq_en[0] |=> capture_irq[0]) else $error("irq low");
  chk_wake_gated: assert property (@(posedge core_clk) disable iff (rst)
    !halt_mode |=> !halt_wake) else $error("wake outside halt");

  // Pin checks.
  chk_pwm_set: assert property (@(posedge core_clk) disable iff (rst)
    ovf_evt && !halt_mode |=> ##1 pwm_out_pin[2] == !pwm_control.polarity[2])
    else $error("pwm level");
  chk_raw_restore: assert property (@(posedge core_clk) disable iff (rst)
    count_tick && counter_reg == compare_shadow[0] && !ovf_evt |=> !pwm_raw_reg[0])
    else $error("compare did not restore");
  chk_halt_freeze: assert property (@(posedge core_clk) disable iff (rst)
    halt_mode |=> $stable(pwm_raw_reg)) else $error("pwm moved in halt");
  chk_oe_follow: assert property (@(posedge core_clk) disable iff (rst)
    pwm_control.out_enable[0] |=> !pwm_out_oe_n[0]) else $error("pin not driven");
endmodule
`default_nettype wire

// File: test/artp_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module artp_pin_model
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ev_go,
  input wire logic [7:0] ev_num,
  input wire logic [1:0] cap_lvl,
  output logic ev_busy,
  output logic ext_clk_pin,
  output logic [1:0] capture_input_pin
);
  logic [7:0] left_reg;
  logic [2:0] ph_reg;
  // Event bursts: 4 cycles high, 4 low, slow enough for the pin synchroniser.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      left_reg <= 8'h00;
    else if (ev_go)
      left_reg <= ev_num;
    else if (ev_busy && ph_reg == 3'h7)
      left_reg <= left_reg - 8'h01;
    if (rst || ev_go)
      ph_reg <= 3'h0;
    else if (ev_busy)
      ph_reg <= ph_reg + 3'h1;
  end
  // The event clock rests low between bursts.
  assign ev_busy = (left_reg != 8'h00);
  assign ext_clk_pin = ev_busy && !ph_reg[2];
  // Capture sources settle one cycle after the bench asks.
  always_ff @(posedge core_clk)
    capture_input_pin <= cap_lvl;
endmodule
`default_nettype wire

// File: test/auto_reload_pwm_capture_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module auto_reload_pwm_capture_timer_tb_top;
  logic core_clk, rst, avs_read, avs_write, halt_mode, ev_go;
  logic [3:0] avs_address, avs_byteenable, pwm_out_pin, pwm_out_oe_n;
  logic [31:0] avs_writedata, avs_readdata;
  logic avs_waitrequest, ext_clk_pin, overflow_irq, halt_wake, ev_busy;
  logic [1:0] capture_input_pin, capture_irq, cap_lvl;
  logic [7:0] ev_num;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int hi, lo;
  artp_timer artp_timer_inst (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .halt_mode(halt_mode), .ext_clk_pin(ext_clk_pin),
    .capture_input_pin(capture_input_pin), .pwm_out_pin(pwm_out_pin),
    .pwm_out_oe_n(pwm_out_oe_n), .overflow_irq(overflow_irq), .capture_irq(capture_irq),
    .halt_wake(halt_wake));
  artp_pin_model artp_pin_model_inst (.core_clk(core_clk), .rst(rst), .ev_go(ev_go),
    .ev_num(ev_num), .cap_lvl(cap_lvl), .ev_busy(ev_busy), .ext_clk_pin(ext_clk_pin),
    .capture_input_pin(capture_input_pin));
  // Clock at 200 MHz.
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // A hung wait is cut short well beyond the expected run length.
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      failures++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("Checks: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One bus access; the request stands until waitrequest is sampled low.
  // Only the bench timeout ends a wait that never sees waitrequest low.
  task automatic bus(input logic is_wr, input logic [3:0] a, input logic [7:0] d,
    output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_read <= !is_wr;
    avs_write <= is_wr;
    do
    begin
      @(posedge core_clk);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h000000, e});
  endtask
  // Counts cycles while a PWM pin holds a level; bounded so a stuck pin ends it.
  task automatic run_len(input int ch, input logic lvl, output int n);
    n = 0;
    while (pwm_out_pin[ch] === lvl && n < 9000)
    begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic meas(input int ch);
    run_len(ch, 1'b1, hi);
    run_len(ch, 1'b0, lo);
    run_len(ch, 1'b1, hi);
    run_len(ch, 1'b0, lo);
  endtask
  // Counts the cycles out of n in which a PWM pin is high.
  task automatic high_cnt(input int ch, input int n, output int h);
    h = 0;
    repeat (n)
    begin
      @(posedge core_clk);
      if (pwm_out_pin[ch] === 1'b1)
        h++;
    end
  endtask
  initial
  begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    halt_mode = 1'b0;
    ev_go = 1'b0;
    ev_num = 8'h00;
    cap_lvl = 2'b10;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    // Every register, plus one unmapped word, reads zero after reset.
    for (int a = 0; a < 12; a++)
      rdc(a[3:0], 8'h00);
    chk(pwm_out_oe_n, 4'hF);
    wr(4'hB, 8'h5A);
    rdc(4'hB, 8'h00);
    // Duty above reload so that a pulse appears.
    wr(4'h7, 8'hF0);
    wr(4'h3, 8'hF3);
    wr(4'h4, 8'h10);
    // The enable lands at the write edge and reaches the pin register one edge later.
    @(posedge core_clk);
    chk(pwm_out_oe_n, 4'hE);
    for (int dv = 0; dv < 3; dv++)
    begin
      wr(4'h5, 8'h0C | (dv[7:0] << 4));
      meas(0);
      chk(hi, 4 << dv);
      chk(hi + lo, 16 << dv);
    end
    wr(4'h5, 8'h0C);
    wr(4'h4, 8'h11);
    meas(0);
    chk(hi, 12);
    chk(lo, 4);
    // Reload zero with duty FFh keeps one level all period; polarity picks 0% or 100%.
    wr(4'h7, 8'h00);
    wr(4'h3, 8'hFF);
    wr(4'h5, 8'h0C);
    repeat (300) @(posedge core_clk);
    high_cnt(0, 256, hi);
    chk(hi, 0);
    wr(4'h4, 8'h10);
    high_cnt(0, 256, hi);
    chk(hi, 256);
    wr(4'h5, 8'h02);
    @(posedge core_clk);
    chk(overflow_irq, 1'b1);
    rdc(4'h5, 8'h03);
    @(posedge core_clk);
    chk(overflow_irq, 1'b0);
    rdc(4'h5, 8'h02);
    wr(4'h6, 8'h20);
    repeat (20) @(posedge core_clk);
    rdc(4'h6, 8'h20);
    // External events: three from FDh reach the overflow.
    wr(4'h7, 8'hFD);
    wr(4'h5, 8'h84);
    rdc(4'h6, 8'hFD);
    wr(4'h5, 8'h88);
    rdc(4'h5, 8'h88);
    for (int k = 0; k < 2; k++)
    begin
      ev_num <= k ? 8'h01 : 8'h02;
      ev_go <= 1'b1;
      @(posedge core_clk);
      ev_go <= 1'b0;
      @(posedge core_clk);
      while (ev_busy === 1'b1)
        @(posedge core_clk);
      repeat (4) @(posedge core_clk);
      if (k == 0)
        rdc(4'h6, 8'hFF);
    end
    rdc(4'h5, 8'h89);
    // The counter is stopped before halt so no stray counts land.
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h42);
    wr(4'h8, 8'h1C);
    cap_lvl <= 2'b11;
    repeat (8) @(posedge core_clk);
    chk(capture_irq, 2'b01);
    halt_mode <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(halt_wake, 1'b1);
    halt_mode <= 1'b0;
    wr(4'h6, 8'h55);
    cap_lvl <= 2'b00;
    repeat (8) @(posedge core_clk);
    cap_lvl <= 2'b01;
    repeat (8) @(posedge core_clk);
    rdc(4'h8, 8'h1F);
    rdc(4'h9, 8'h42);
    @(posedge core_clk);
    chk(capture_irq, 2'b10);
    rdc(4'hA, 8'h55);
    rdc(4'h8, 8'h1C);
    finish_test();
  end
endmodule
`default_nettype wire
